// file: verilog/ppm_top.sv
/*
  PCI power state manager: power state field, clock and interrupt
  gating, recovery latency, wake (PME#) signalling and the read-only
  power management capability dwords in PCI config space.
  Assumes config accesses come from the PCI target logic on sys_clk,
  wake events arrive asynchronously from the serial-bus side, and
  the soft reset and interrupt cause come from logic on sys_clk.
*/
// Overview of operation
// RQ1 - host writes state field for D0/D2
// RQ2 - state codes 00 D0, 10 D2, 11 D3hot
// RQ3 - D0: full clocks, transfers, interrupts
// RQ4 - D2: main clocks stopped, power kept
// RQ5 - D2 entry drops ROM, keeps config, GUID
// RQ6 - D2/D3hot: interrupt output held off
// RQ7 - D2 to D0 takes 200us
// RQ8 - soft reset bit leaves D3hot for D0
// RQ9 - D3hot drops ROM and config, keeps GUID
// RQ10 - leaving D3hot takes 10ms
// RQ11 - D3cold: system asserts PCI reset after power
// RQ12 - D3cold: no interrupt, no wake
// RQ13 - D2/D3hot wake on packet or bus reset
// RQ14 - PME# drops on status write or enable clear
// RQ15 - status bit 15 shows PME#, one clears
// RQ16 - enable bit 8 gates any PME#
// RQ17 - capability pointer reports block location
// RQ18 - capability identifier reads 01h
// RQ19 - next capability pointer reads 00h
// RQ20 - wake support field reads 0Ch
// RQ21 - D2 supported, D1 not
// RQ22 - auxiliary current reads 000b
// RQ23 - wake-needs-clock and DSI read zero
// RQ24 - version field reads 010b
// RQ25 - forbidden state code leaves state unchanged
`timescale 1ns/1ps
`include "ppm_cfg.svh"
`default_nettype none
module ppm_top #(
  parameter int unsigned D3_EXIT_CYCLES = `PPM_D3_EXIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // config space access
  input wire ppm_pkg::ppm_cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic cfg_hit,
  output logic [31:0] cfg_rdata,
  // serial-bus events, asynchronous
  input wire logic packet_rx,
  input wire logic bus_reset,
  // controller side
  input wire logic controller_soft_reset_bit,
  input wire logic int_cause,
  // gating and state losses
  output ppm_pkg::ppm_gate_t gate,
  output logic cfg_rom_clear,
  output logic cfg_space_clear,
  output logic recovering,
  // PME# open-drain pin, low while driven
  output logic pme_o,
  output logic pme_oe
);
  localparam logic [`PPM_TIMER_W-1:0] D2_EXIT_LOAD = `PPM_TIMER_W'(`PPM_D2_EXIT_CYC);
  localparam logic [`PPM_TIMER_W-1:0] D3_EXIT_LOAD = `PPM_TIMER_W'(D3_EXIT_CYCLES);

  ppm_pkg::ppm_state_t state;
  ppm_pkg::ppm_state_t next_state;
  logic wake_enable_bit;
  logic wake_status_bit;
  logic [1:0] wake_pulse;
  logic wake_event;
  logic timer_load;
  logic [`PPM_TIMER_W-1:0] timer_value;
  logic timer_busy;
  logic power_control_status_reg_wr_lo;
  logic power_control_status_reg_wr_hi;
  logic [1:0] req_state;
  logic [1:0] power_state_field;
  logic [31:0] next_rdata;
  logic next_hit;

  // byte-lane write decode for one config dword
  function automatic logic lane_write(input ppm_pkg::ppm_cfg_req_t r,
                                      input logic [5:0] idx, input int lane);
    lane_write = r.sel && r.wr && (r.idx == idx) && r.be[lane];
  endfunction

  // encoding of the state a given machine state reports
  function automatic logic [1:0] state_code(input ppm_pkg::ppm_state_t s);
    case (s)
      ppm_pkg::PPM_ST_D2: state_code = `PPM_PS_D2;
      ppm_pkg::PPM_ST_D3HOT: state_code = `PPM_PS_D3HOT;
      default: state_code = `PPM_PS_D0;
    endcase
  endfunction

  // low-power states, where wake is armed and the ROM is lost
  function automatic logic low_power(input ppm_pkg::ppm_state_t s);
    low_power = (s == ppm_pkg::PPM_ST_D2) || (s == ppm_pkg::PPM_ST_D3HOT);
  endfunction

  // host write of one power state code
  function automatic logic state_write(input logic wr_lo, input logic [1:0] req,
                                       input logic [1:0] code);
    state_write = wr_lo && (req == code);
  endfunction

  ppm_edge_sync #(
    .W(2)
  ) u_wake_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({bus_reset, packet_rx}),
    .rise_pulse(wake_pulse)
  );

  ppm_delay_timer u_exit_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(timer_load),
    .load_value(timer_value),
    .busy(timer_busy)
  );

  assign power_control_status_reg_wr_lo = lane_write(cfg_req, `PPM_POWER_CONTROL_STATUS_REG_IDX, 0);
  assign power_control_status_reg_wr_hi = lane_write(cfg_req, `PPM_POWER_CONTROL_STATUS_REG_IDX, 1);
  assign req_state = cfg_req.wdata[`PPM_STATE_LSB +: 2];
  assign power_state_field = state_code(state);
  // RQ13 wake only in D2/D3hot
  assign wake_event = (wake_pulse != 2'h0) && low_power(state);

  // power state transitions
  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = D2_EXIT_LOAD;
    case (state)
      ppm_pkg::PPM_ST_D0:
      begin
        // RQ1 RQ2 host-written state
        if (state_write(power_control_status_reg_wr_lo, req_state, `PPM_PS_D2))
          next_state = ppm_pkg::PPM_ST_D2;
        else if (state_write(power_control_status_reg_wr_lo, req_state, `PPM_PS_D3HOT))
          next_state = ppm_pkg::PPM_ST_D3HOT;
      end
      ppm_pkg::PPM_ST_RECOVER:
      begin
        // state writes are ignored until the timer empties
        if (!timer_busy)
          next_state = ppm_pkg::PPM_ST_D0;
      end
      ppm_pkg::PPM_ST_D2:
      begin
        // RQ7 D2 exit latency
        if (state_write(power_control_status_reg_wr_lo, req_state, `PPM_PS_D0))
        begin
          next_state = ppm_pkg::PPM_ST_RECOVER;
          timer_load = 1'b1;
          timer_value = D2_EXIT_LOAD;
        end
        else if (state_write(power_control_status_reg_wr_lo, req_state, `PPM_PS_D3HOT))
          next_state = ppm_pkg::PPM_ST_D3HOT;
      end
      ppm_pkg::PPM_ST_D3HOT:
      begin
        // RQ8 RQ10 soft reset exit, 10ms
        if (controller_soft_reset_bit)
        begin
          next_state = ppm_pkg::PPM_ST_RECOVER;
          timer_load = 1'b1;
          timer_value = D3_EXIT_LOAD;
        end
      end
      default:
        next_state = ppm_pkg::PPM_ST_D0;
    endcase
    // RQ25 forbidden code ignored
    if (state_write(power_control_status_reg_wr_lo, req_state, `PPM_PS_D1) && (state != ppm_pkg::PPM_ST_D3HOT))
      next_state = state;
  end

  // RQ11 RQ12 reset covers D3cold power-up
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      state <= ppm_pkg::PPM_ST_D0;
    else
      state <= next_state;
  end

  // RQ16 wake enable bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      wake_enable_bit <= `PPM_WAKE_EN_RESET;
    else if (power_control_status_reg_wr_hi)
      wake_enable_bit <= cfg_req.wdata[`PPM_WAKE_EN_BIT];
  end

  // RQ15 sticky status, set wins over one-write clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      wake_status_bit <= `PPM_WAKE_ST_RESET;
    else if (wake_event && wake_enable_bit)
      wake_status_bit <= 1'b1;
    else if (power_control_status_reg_wr_hi && cfg_req.wdata[`PPM_WAKE_ST_BIT])
      wake_status_bit <= 1'b0;
  end

  // open drain: pme_o stays low, pme_oe pulls the pin
  // RQ14 PME# follows status and enable
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pme_oe <= 1'b0;
      pme_o <= 1'b0;
    end
    else
    begin
      pme_oe <= (wake_status_bit && wake_enable_bit) || (wake_event && wake_enable_bit);
      pme_o <= 1'b0;
    end
  end

  // recovery keeps the core clocked but holds transfers off
  // clock and interrupt gating
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      gate <= '0;
    else
    begin
      // RQ3 full operation only in D0
      gate.core_clk_en <= (next_state == ppm_pkg::PPM_ST_D0) ||
                          (next_state == ppm_pkg::PPM_ST_RECOVER);
      gate.xfer_en <= (next_state == ppm_pkg::PPM_ST_D0);
      // RQ4 RQ6 low power gates interrupts
      gate.int_out <= int_cause && (next_state == ppm_pkg::PPM_ST_D0);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      recovering <= 1'b0;
    else
      recovering <= (next_state == ppm_pkg::PPM_ST_RECOVER);
  end

  // state losses on low-power entry
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cfg_rom_clear <= 1'b0;
      cfg_space_clear <= 1'b0;
    end
    else
    begin
      // RQ5 RQ9 ROM lost in D2 and D3hot
      cfg_rom_clear <= (state != next_state) && low_power(next_state);
      // RQ9 config space lost in D3hot only
      cfg_space_clear <= (state != ppm_pkg::PPM_ST_D3HOT) &&
                         (next_state == ppm_pkg::PPM_ST_D3HOT);
    end
  end

  // config read decode
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_hit = 1'b0;
    if (cfg_req.sel)
    begin
      case (cfg_req.idx)
        `PPM_CAP_PTR_IDX:
        begin
          // RQ17 capability pointer
          next_rdata[7:0] = `PPM_CAP_OFFSET;
          next_hit = 1'b1;
        end
        `PPM_PM_CAP_IDX:
        begin
          // RQ18 RQ19 identifier and next pointer
          next_rdata[7:0] = `PPM_CAPABILITY_IDENTIFIER;
          next_rdata[15:8] = `PPM_NEXT_PTR;
          // RQ20 RQ21 wake support, state flags
          next_rdata[31:27] = `PPM_WAKE_SUPPORT;
          next_rdata[26] = `PPM_STATE_TWO_SUPPORT;
          next_rdata[25] = `PPM_STATE_ONE_SUPPORT;
          // RQ22 RQ23 aux current, DSI, clock flag
          next_rdata[24:22] = `PPM_AUX_CURRENT;
          next_rdata[21] = `PPM_DSI;
          next_rdata[19] = `PPM_WAKE_NEEDS_CLOCK;
          // RQ24 version
          next_rdata[18:16] = `PPM_CAP_VERSION;
          next_hit = 1'b1;
        end
        `PPM_POWER_CONTROL_STATUS_REG_IDX:
        begin
          // recovery reads back as D0; data scale and select read zero
          next_rdata[`PPM_STATE_LSB +: 2] = power_state_field;
          next_rdata[`PPM_WAKE_EN_BIT] = wake_enable_bit;
          next_rdata[`PPM_WAKE_ST_BIT] = wake_status_bit;
          next_hit = 1'b1;
        end
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_hit = 1'b0;
        end
      endcase
    end
  end

  // one-cycle registered answer to every access
  // write cycles answer too; the host ignores their data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cfg_ack <= 1'b0;
      cfg_hit <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack <= cfg_req.sel;
      cfg_hit <= next_hit;
      cfg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// file: verilog/ppm_cfg.svh
/*
  Constants for the PCI power state manager: config-space placement,
  field positions, read-only capability values and recovery times.
  Assumes a 10 MHz sys_clk; included by ppm_top and ppm_delay_timer.
*/
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// config-space dword indexes (byte address / 4)
`define PPM_CAP_PTR_IDX 6'h0D
`define PPM_PM_CAP_IDX 6'h10
`define PPM_POWER_CONTROL_STATUS_REG_IDX 6'h11
// byte offset of the power management block, reported by the cap pointer
`define PPM_CAP_OFFSET 8'h40

// capability dword fields
`define PPM_CAPABILITY_IDENTIFIER 8'h01
`define PPM_NEXT_PTR 8'h00
`define PPM_WAKE_SUPPORT 5'h0C
`define PPM_STATE_TWO_SUPPORT 1'h1
`define PPM_STATE_ONE_SUPPORT 1'h0
`define PPM_AUX_CURRENT 3'h0
`define PPM_DSI 1'h0
`define PPM_WAKE_NEEDS_CLOCK 1'h0
`define PPM_CAP_VERSION 3'h2

// control/status field positions and reset values
`define PPM_STATE_LSB 0
`define PPM_WAKE_EN_BIT 8
`define PPM_WAKE_ST_BIT 15
`define PPM_WAKE_EN_RESET 1'h0
`define PPM_WAKE_ST_RESET 1'h0

// power state field encodings
`define PPM_PS_D0 2'h0
`define PPM_PS_D1 2'h1
`define PPM_PS_D2 2'h2
`define PPM_PS_D3HOT 2'h3

// recovery times and derived cycle counts (least times, rounded up)
`define PPM_CLK_PERIOD_NS 100
`define PPM_D2_EXIT_NS 200000
`define PPM_D3_EXIT_NS 10000000
`define PPM_D2_EXIT_CYC ((`PPM_D2_EXIT_NS + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_D3_EXIT_CYC ((`PPM_D3_EXIT_NS + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_TIMER_W 17

`endif

// file: verilog/ppm_pkg.sv
/*
  Types for the PCI power state manager.
  Assumes ppm_cfg.svh is compiled alongside.
*/
package ppm_pkg;

  typedef enum logic [1:0] {
    PPM_ST_D0,
    PPM_ST_RECOVER,
    PPM_ST_D2,
    PPM_ST_D3HOT
  } ppm_state_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [5:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } ppm_cfg_req_t;

  typedef struct packed {
    logic core_clk_en;
    logic xfer_en;
    logic int_out;
  } ppm_gate_t;

endpackage

// file: verilog/ppm_edge_sync.sv
/*
  Two-flop synchroniser with rising-edge pulse, per bit.
  Assumes inputs are asynchronous levels from the serial-bus side.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_edge_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // levels in, pulses out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] rise_pulse
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end
    else
    begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign rise_pulse = sync & ~last;
endmodule
`default_nettype wire

// file: verilog/ppm_delay_timer.sv
/*
  Down counter that stays busy for a loaded number of cycles.
  Assumes load is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/1ps
`include "ppm_cfg.svh"
`default_nettype none
module ppm_delay_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [`PPM_TIMER_W-1:0] load_value,
  output logic busy
);
  logic [`PPM_TIMER_W-1:0] count;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - `PPM_TIMER_W'(1);
  end

  assign busy = (count != '0);
endmodule
`default_nettype wire

// file: verif/ppm_props.sv
/*
  Checker for ppm_top, bound to its ports.
  Assumes one sys_clk domain with synchronous active-low rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // config bus
  input wire ppm_pkg::ppm_cfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic cfg_hit,
  input wire logic [31:0] cfg_rdata,
  // controller and outputs
  input wire logic int_cause,
  input wire ppm_pkg::ppm_gate_t gate,
  input wire logic cfg_rom_clear,
  input wire logic cfg_space_clear,
  input wire logic recovering,
  input wire logic pme_o,
  input wire logic pme_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic miss;
  logic cap_rd;
  assign miss = cfg_req.sel && !(cfg_req.idx inside {6'h0D, 6'h10, 6'h11});
  assign cap_rd = cfg_req.sel && !cfg_req.wr && cfg_req.idx == 6'h10;
  ack_after_sel_a: assert property (cfg_req.sel |=> cfg_ack)
    else $error("no ack after access");
  no_stray_ack_a: assert property (!cfg_req.sel |=> !cfg_ack)
    else $error("ack without access");
  unmapped_quiet_a: assert property (miss |=> !cfg_hit && cfg_rdata == 32'h0)
    else $error("unmapped dword answered");
  cap_dword_a: assert property (cap_rd |=> cfg_hit && cfg_rdata == 32'h64020001)
    else $error("capability dword wrong");
  pme_low_a: assert property (pme_o == 1'b0)
    else $error("wake pin driven high");
  asleep_gates_a: assert property (!gate.core_clk_en |-> !gate.int_out && !gate.xfer_en)
    else $error("activity while asleep");
  int_from_cause_a: assert property (gate.int_out |-> $past(int_cause))
    else $error("interrupt without cause");
  recover_gate_a: assert property (recovering |-> !gate.xfer_en && gate.core_clk_en)
    else $error("transfers during recovery");
  rom_pulse_a: assert property (cfg_rom_clear |=> !cfg_rom_clear)
    else $error("rom clear not a pulse");
  space_rom_a: assert property (cfg_space_clear |-> cfg_rom_clear)
    else $error("space clear without rom clear");
  wake_asleep_a: assert property ($rose(pme_oe) |-> !gate.core_clk_en)
    else $error("wake raised while awake");
  cover property (recovering);
  cover property (pme_oe);
  cover property (cfg_space_clear);
endmodule
bind ppm_top ppm_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_req(cfg_req),
  .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .int_cause(int_cause),
  .gate(gate), .cfg_rom_clear(cfg_rom_clear), .cfg_space_clear(cfg_space_clear),
  .recovering(recovering), .pme_o(pme_o), .pme_oe(pme_oe));
`default_nettype wire

// file: verif/ppm_host_model.sv
/*
  Host side: config accesses, soft reset, recovery wait.
  Assumes calls start and end 1 ns after a sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_host_model (
  // clock
  input wire logic sys_clk,
  // toward the device
  output ppm_pkg::ppm_cfg_req_t cfg_req,
  output logic controller_soft_reset_bit,
  // device status
  input wire logic recovering
);
  initial
  begin
    cfg_req = '0;
    controller_soft_reset_bit = 1'b0;
  end
  // state moves via the state field
  task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd);
    cfg_req = {1'b1, wr, idx, be, wd};
    @(posedge sys_clk);
    #1;
  endtask
  task automatic idle(input int n);
    cfg_req.sel = 1'b0;
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic soft_reset();
    controller_soft_reset_bit = 1'b1;
    idle(1 + $urandom_range(0, 2));
    controller_soft_reset_bit = 1'b0;
  endtask
  task automatic wait_ready(input int lim, output int n);
    n = 0;
    while (recovering === 1'b1 && n < lim)
    begin
      idle(1);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
/*
  Testbench for ppm_top with a host model.
  Assumes a 10 MHz clock and a shortened D3hot exit.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst_b, packet_rx, bus_reset, int_cause, srst;
  ppm_pkg::ppm_cfg_req_t req;
  logic ack, hit, rom_clr, spc_clr, recovering, pme_o, pme_oe;
  logic [31:0] rdata;
  ppm_pkg::ppm_gate_t gate;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  ppm_top #(.D3_EXIT_CYCLES(50)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_req(req),
    .cfg_ack(ack), .cfg_hit(hit), .cfg_rdata(rdata), .packet_rx(packet_rx),
    .bus_reset(bus_reset), .controller_soft_reset_bit(srst), .int_cause(int_cause),
    .gate(gate), .cfg_rom_clear(rom_clr), .cfg_space_clear(spc_clr),
    .recovering(recovering), .pme_o(pme_o), .pme_oe(pme_oe));
  ppm_host_model host (.sys_clk(sys_clk), .cfg_req(req), .controller_soft_reset_bit(srst),
    .recovering(recovering));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] v,
                    input logic h);
    exp_q.push_back({h, m, v});
    host.access(1'b0, idx, 4'h0, 32'h0);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    exp_q.push_back({idx inside {6'h0D, 6'h10, 6'h11}, 64'h0});
    host.access(1'b1, idx, be, wd);
  endtask
  task automatic wake(input logic pin, input logic want);
    if (pin)
      bus_reset = 1'b1;
    else
      packet_rx = 1'b1;
    host.idle(7);
    check({31'h0, pme_oe}, {31'h0, want});
    bus_reset = 1'b0;
    packet_rx = 1'b0;
    host.idle(3);
  endtask
  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // results leave one cycle after the access
  always @(negedge sys_clk)
    if (ack === 1'b1)
    begin
      e = exp_q.pop_front();
      check({31'h0, hit}, {31'h0, e[64]});
      check(rdata & e[63:32], e[31:0]);
    end
  initial
  begin
    rst_b = 1'b0;
    packet_rx = 1'b0;
    bus_reset = 1'b0;
    int_cause = 1'b0;
    void'($urandom(36));
    repeat (4) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    rd(6'h10, 32'hFFFFFFFF, 32'h64020001, 1'b1);
    rd(6'h0D, 32'hFF, 32'h40, 1'b1);
    wr(6'h10, 4'hF, $urandom());
    rd(6'h10, 32'hFFFFFFFF, 32'h64020001, 1'b1);
    rd(6'h11, 32'hFFFF, 32'h0, 1'b1);
    int_cause = 1'($urandom());
    repeat (4) rd(6'($urandom_range(0, 12)), 32'hFFFFFFFF, 32'h0, 1'b0);
    int_cause = 1'b1;
    host.idle(3);
    check({30'h0, gate.int_out, gate.xfer_en}, 32'h3);
    wr(6'h11, 4'h2, 32'h100);
    {bus_reset, packet_rx} = 2'($urandom_range(1, 3));
    host.idle(5);
    check({31'h0, pme_oe}, 32'h0);
    {bus_reset, packet_rx} = 2'h0;
    rd(6'h11, 32'hFFFF, 32'h100, 1'b1);
    wr(6'h11, 4'h2, 32'h0);
    wr(6'h11, 4'h1, 32'h1);
    rd(6'h11, 32'h3, 32'h0, 1'b1);
    wr(6'h11, 4'h1, 32'h2);
    check({30'h0, rom_clr, gate.core_clk_en}, 32'h2);
    host.idle(1);
    host.idle(2);
    check({31'h0, gate.int_out}, 32'h0);
    int_cause = 1'($urandom());
    rd(6'h11, 32'hFFFF, 32'h2, 1'b1);
    wake(1'b0, 1'b0);
    wr(6'h11, 4'h2, 32'h100);
    wake(1'b1, 1'b1);
    rd(6'h11, 32'hFFFF, 32'h8102, 1'b1);
    wr(6'h11, 4'h2, 32'h8100);
    host.idle(3);
    check({31'h0, pme_oe}, 32'h0);
    wake(1'b0, 1'b1);
    wr(6'h11, 4'h2, 32'h0);
    host.idle(3);
    check({31'h0, pme_oe}, 32'h0);
    wr(6'h11, 4'h2, 32'h8000);
    wr(6'h11, 4'h1, 32'h0);
    check({31'h0, recovering}, 32'h1);
    host.wait_ready(2100, n);
    check({31'h0, n >= 1995 && n <= 2003}, 32'h1);
    host.idle(2);
    check({30'h0, gate.int_out, gate.xfer_en}, {30'h0, int_cause, 1'b1});
    wr(6'h11, 4'h1, 32'h3);
    check({30'h0, spc_clr, rom_clr}, 32'h3);
    wr(6'h11, 4'h1, 32'h0);
    rd(6'h11, 32'hFFFF, 32'h3, 1'b1);
    host.soft_reset();
    host.wait_ready(100, n);
    check({31'h0, n >= 45 && n <= 53}, 32'h1);
    host.idle(2);
    rd(6'h11, 32'h3, 32'h0, 1'b1);
    wr(6'h11, 4'h1, 32'h2);
    host.idle(1);
    wr(6'h11, 4'h1, 32'h3);
    check({30'h0, spc_clr, rom_clr}, 32'h3);
    host.soft_reset();
    host.wait_ready(100, n);
    check({31'h0, n >= 45 && n <= 53}, 32'h1);
    host.idle(3);
    check(exp_q.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
